//--- design/dfac_channel.sv
// full address mode channel pair: counters, control and bus requests
// Operation
// - full address mode ignores peripheral address registers, uses memory address pair
// - normal mode: count_a counts down per transfer, ends at zero
// - normal mode leaves count_b unused
// - block mode: high byte counts per unit, reloads from low byte at one
// - block mode: count_b counts blocks, transfer ends at zero
// - count registers untouched by reset and standby
// - channel_a_control clears to zero on reset and standby
// - full address mode when both upper select bits are one
// - enabled only when channel enable and master enable are both one
// - auto-request starts at once, else wait for request
// - channel enable self-clears at completion; disabled channel rejects requests
// - clearing channel enable while no unit is on the bus raises end interrupt when its enable bit set
// - bits 5 and 4 hold, increment or decrement source address
// - step is 1 for bytes, 2 for words
// - bit 0 selects normal or block transfer mode
// - bit 6 selects byte or word unit
// - source from channel-A address, destination from channel-B address
// - non-maskable interrupt clears master enable; resumes when set again
`timescale 1ns/1ps
module dfac_channel
  import dfac_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_standby,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // events
  input wire logic i_nmi,
  input wire logic i_xfer_req,
  // transfer bus
  output logic o_xfer_valid,
  output logic [31:0] o_src_addr,
  output logic [31:0] o_dst_addr,
  output logic o_word,
  input wire logic i_xfer_done,
  // interrupt to cpu
  output logic o_transfer_end_irq
);
  import dfac_pkg::*;

  // register map on the plain port, one word per address
  // 0: channel_a_control, enable, unit, source step and mode bits
  // 1: channel_b_control, master enable, destination step and request select
  // 2: count_a, low 16 bits
  // 3: count_b, low 16 bits
  // 4: src_addr_reg, top byte reads as ones
  // 5: dst_addr_reg, top byte reads as ones
  // 6: sequencer status, one-hot state in the low bits
  // unmapped reads return zero, unmapped writes are dropped

  // strobe qualified by one register address
  function automatic logic reg_sel(input logic strobe, input logic [3:0] addr, input logic [3:0] target);
    return strobe && (addr == target);
  endfunction

  // block size counter at the final unit of its block
  function automatic logic block_end(input logic [15:0] cnt);
    return cnt[15:8] == 8'h01;
  endfunction

  // sequencer: idle while off, wait while enabled, xfer while a unit is on the bus
  dfac_state_t state, next_state;
  // software-visible control registers
  logic [7:0] channel_a_control, next_channel_a_control;
  logic [7:0] channel_b_control, next_channel_b_control;
  // transfer counters and addresses, kept through reset
  logic [15:0] count_a, next_count_a;
  logic [15:0] count_b, next_count_b;
  logic [31:0] src_addr_reg, next_src_addr_reg;
  logic [31:0] dst_addr_reg, next_dst_addr_reg;
  // read-then-write arming flags
  logic armed_a, next_armed_a;
  logic armed_b, next_armed_b;
  // registered outputs
  logic [31:0] rdata, next_rdata;
  logic irq, next_irq;
  logic valid, next_valid;
  logic [31:0] src_step, dst_step;
  logic full_mode, block_mode, enabled, auto_req, last;
  logic wr_ca, wr_cb;
  // qualified write strobes for counts and addresses
  logic wr_cnt_a, wr_cnt_b, wr_src, wr_dst;
  // the bus has taken the current unit
  logic unit_done;

  // mode and enable decode
  always_comb begin
    full_mode = channel_a_control[CA_SEL_HI] & channel_a_control[CA_SEL_LO];
    block_mode = full_mode & channel_a_control[CA_BLOCK];
    enabled = full_mode & channel_a_control[CA_ENABLE] & channel_b_control[CB_MASTER];
    auto_req = ~channel_b_control[CB_AUTO_HI];
    // final unit of the programmed transfer
    if (block_mode) begin
      last = block_end(count_a) && (count_b == 16'h0001);
    end else begin
      last = (count_a == 16'h0001);
    end
    // register write strobes, one per target
    wr_ca = reg_sel(i_reg_wr, i_reg_addr, ADDR_CTRL_A);
    wr_cb = reg_sel(i_reg_wr, i_reg_addr, ADDR_CTRL_B);
    wr_cnt_a = reg_sel(i_reg_wr, i_reg_addr, ADDR_COUNT_A);
    wr_cnt_b = reg_sel(i_reg_wr, i_reg_addr, ADDR_COUNT_B);
    wr_src = reg_sel(i_reg_wr, i_reg_addr, ADDR_SRC);
    wr_dst = reg_sel(i_reg_wr, i_reg_addr, ADDR_DST);
    // unit finished only counts while one is on the bus
    unit_done = (state == DFAC_XFER) && i_xfer_done;
  end

  // address steppers, source and destination
  dfac_addr_step u_src_step (
    .i_step_en(channel_a_control[CA_STEP_EN]),
    .i_step_dir(channel_a_control[CA_STEP_DIR]),
    .i_word(channel_a_control[CA_UNIT]),
    .i_addr(src_addr_reg),
    .o_addr(src_step)
  );
  dfac_addr_step u_dst_step (
    .i_step_en(channel_b_control[CB_DST_EN]),
    .i_step_dir(channel_b_control[CB_DST_DIR]),
    .i_word(channel_a_control[CA_UNIT]),
    .i_addr(dst_addr_reg),
    .o_addr(dst_step)
  );

  // next state of sequencer and control registers
  always_comb begin
    next_state = state;
    next_channel_a_control = channel_a_control;
    next_channel_b_control = channel_b_control;
    next_armed_a = armed_a;
    next_armed_b = armed_b;
    next_irq = 1'b0;
    next_valid = valid;
    next_rdata = 32'h0000_0000;

    // software writes to the control registers
    if (wr_ca) begin
      next_channel_a_control = i_reg_wdata[7:0];
      // enable sets only after a read that saw it clear
      // keeps a stray write from restarting a finished channel
      if (!channel_a_control[CA_ENABLE] && !armed_a) begin
        next_channel_a_control[CA_ENABLE] = 1'b0;
      end
      // any write uses up the arming read
      next_armed_a = 1'b0;
    end
    // master enable follows the same read-then-write rule
    if (wr_cb) begin
      next_channel_b_control = i_reg_wdata[7:0];
      if (!channel_b_control[CB_MASTER] && !armed_b) begin
        next_channel_b_control[CB_MASTER] = 1'b0;
      end
      next_armed_b = 1'b0;
    end

    // register reads, data one cycle later
    if (i_reg_rd) begin
      case (i_reg_addr)
        // a read with the bit clear arms the next write
        ADDR_CTRL_A: begin
          next_rdata = {24'h00_0000, channel_a_control};
          if (!channel_a_control[CA_ENABLE]) begin
            next_armed_a = 1'b1;
          end
        end
        ADDR_CTRL_B: begin
          next_rdata = {24'h00_0000, channel_b_control};
          if (!channel_b_control[CB_MASTER]) begin
            next_armed_b = 1'b1;
          end
        end
        ADDR_COUNT_A: next_rdata = {16'h0000, count_a};
        ADDR_COUNT_B: next_rdata = {16'h0000, count_b};
        ADDR_SRC: next_rdata = src_addr_reg;
        ADDR_DST: next_rdata = dst_addr_reg;
        ADDR_STATUS: next_rdata = {29'h0000_0000, state};
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    // transfer sequencer
    case (state)
      // channel off, leave once fully enabled
      DFAC_IDLE: begin
        if (enabled) begin
          next_state = DFAC_WAIT;
        end
      end
      // enabled, waiting for auto-request or an external request
      DFAC_WAIT: begin
        if (!enabled) begin
          next_state = DFAC_IDLE;
        end else if (auto_req || i_xfer_req) begin
          next_state = DFAC_XFER;
          next_valid = 1'b1;
        end
      end
      // unit on the bus, held until the bus reports it done
      DFAC_XFER: begin
        if (unit_done) begin
          next_valid = 1'b0;
          // final unit: drop enable and pulse the end interrupt when its enable bit is set
          if (last) begin
            next_channel_a_control[CA_ENABLE] = 1'b0;
            next_irq = channel_a_control[CA_IRQ_EN];
            next_state = DFAC_IDLE;
          end else begin
            next_state = DFAC_WAIT;
          end
        end
      end
      // illegal code recovers to idle
      default: begin
        next_state = DFAC_IDLE;
        next_valid = 1'b0;
      end
    endcase

    // software clearing enable also ends the transfer
    if (wr_ca && channel_a_control[CA_ENABLE] && !i_reg_wdata[CA_ENABLE] && state != DFAC_XFER) begin
      next_irq = channel_a_control[CA_IRQ_EN];
    end
    // nmi suspends, takes priority over software write
    if (i_nmi) begin
      next_channel_b_control[CB_MASTER] = 1'b0;
    end
    // standby initialises control registers
    if (i_standby) begin
      next_channel_a_control = CTRL_RESET;
      next_channel_b_control = CTRL_RESET;
      next_state = DFAC_IDLE;
      next_valid = 1'b0;
      next_armed_a = 1'b0;
      next_armed_b = 1'b0;
    end
  end

  // next counts and addresses; a unit update beats a same-cycle register write
  always_comb begin
    next_count_a = count_a;
    next_count_b = count_b;
    next_src_addr_reg = src_addr_reg;
    next_dst_addr_reg = dst_addr_reg;
    // count registers, written whole
    if (wr_cnt_a) begin
      next_count_a = i_reg_wdata[15:0];
    end
    if (wr_cnt_b) begin
      next_count_b = i_reg_wdata[15:0];
    end
    // address registers, reserved top byte forced to ones
    if (wr_src) begin
      next_src_addr_reg = i_reg_wdata | ADDR_HI_ONES;
    end
    if (wr_dst) begin
      next_dst_addr_reg = i_reg_wdata | ADDR_HI_ONES;
    end
    // step addresses and counters once the bus has taken a unit
    if (unit_done) begin
      next_src_addr_reg = src_step;
      next_dst_addr_reg = dst_step;
      if (block_mode) begin
        // block size counter at one: reload it and count the block
        if (block_end(count_a)) begin
          next_count_a[15:8] = count_a[7:0];
          next_count_b = count_b - 16'h0001;
        end else begin
          next_count_a[15:8] = count_a[15:8] - 8'h01;
        end
      end else begin
        // normal mode, count_b left alone
        next_count_a = count_a - 16'h0001;
      end
    end
  end

  // control state with reset
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= DFAC_IDLE;
      channel_a_control <= CTRL_RESET;
      channel_b_control <= CTRL_RESET;
      armed_a <= 1'b0;
      armed_b <= 1'b0;
      rdata <= 32'h0000_0000;
      irq <= 1'b0;
      valid <= 1'b0;
    end else begin
      state <= next_state;
      channel_a_control <= next_channel_a_control;
      channel_b_control <= next_channel_b_control;
      armed_a <= next_armed_a;
      armed_b <= next_armed_b;
      rdata <= next_rdata;
      irq <= next_irq;
      valid <= next_valid;
    end
  end

  // counters and addresses, no reset
  always_ff @(posedge i_core_clk) begin
    count_a <= next_count_a;
    count_b <= next_count_b;
    src_addr_reg <= next_src_addr_reg;
    dst_addr_reg <= next_dst_addr_reg;
  end

  // outputs from flip-flops
  assign o_reg_rdata = rdata;
  assign o_xfer_valid = valid;
  assign o_src_addr = src_addr_reg;
  assign o_dst_addr = dst_addr_reg;
  assign o_word = channel_a_control[CA_UNIT];
  assign o_transfer_end_irq = irq;
endmodule

//--- design/dfac_pkg.sv
// constants and types for the full address channel controller
package dfac_pkg;
  // register offsets (word addresses on the plain port)
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT_A = 4'h2;
  localparam logic [3:0] ADDR_COUNT_B = 4'h3;
  localparam logic [3:0] ADDR_SRC = 4'h4;
  localparam logic [3:0] ADDR_DST = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  // channel_a_control fields
  localparam int CA_ENABLE = 7;
  localparam int CA_UNIT = 6;
  localparam int CA_STEP_DIR = 5;
  localparam int CA_STEP_EN = 4;
  localparam int CA_IRQ_EN = 3;
  localparam int CA_SEL_HI = 2;
  localparam int CA_SEL_LO = 1;
  localparam int CA_BLOCK = 0;
  // channel_b_control fields
  localparam int CB_MASTER = 7;
  localparam int CB_DST_DIR = 5;
  localparam int CB_DST_EN = 4;
  localparam int CB_AUTO_HI = 2;
  localparam int CB_AUTO_LO = 1;
  // control reset value and address top-byte ones
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] ADDR_HI_ONES = 32'hFF00_0000;
  // address steps
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  // channel states
  typedef enum logic [2:0] {
    DFAC_IDLE = 3'b001,
    DFAC_WAIT = 3'b010,
    DFAC_XFER = 3'b100
  } dfac_state_t;
endpackage

//--- design/dfac_addr_step.sv
// source or destination address stepper
`timescale 1ns/1ps
module dfac_addr_step
  import dfac_pkg::*;
(
  // settings
  input wire logic i_step_en,
  input wire logic i_step_dir,
  input wire logic i_word,
  // address
  input wire logic [31:0] i_addr,
  output logic [31:0] o_addr
);
  logic [31:0] step;

  // step by 1 or 2, up or down, or hold
  always_comb begin
    step = i_word ? STEP_WORD : STEP_BYTE;
    if (!i_step_en) begin
      o_addr = i_addr;
    end else if (i_step_dir) begin
      o_addr = i_addr - step;
    end else begin
      o_addr = i_addr + step;
    end
  end
endmodule

//--- test/dfac_channel_monitor.sv
// port assertions for the channel controller
`timescale 1ns/1ps
module dfac_channel_monitor (
  // clock and control inputs
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_standby,
  input wire logic i_reg_wr,
  input wire logic i_nmi,
  input wire logic i_xfer_done,
  // outputs watched
  input wire logic o_xfer_valid,
  input wire logic o_word,
  input wire logic [31:0] o_src_addr,
  input wire logic [31:0] o_dst_addr,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_transfer_end_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic dn;
  logic [31:0] ps, df;
  // source address step over one finished unit
  assign dn = o_xfer_valid && i_xfer_done && !i_reg_wr;
  assign df = o_src_addr - ps;
  always_ff @(posedge i_core_clk) begin
    ps <= o_src_addr;
  end
  property p_hold;
    o_xfer_valid && !i_xfer_done && !i_reg_wr |=> o_xfer_valid && $stable(o_src_addr) && $stable(o_dst_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("unit left the bus early");
  property p_drop;
    o_xfer_valid && i_xfer_done |=> !o_xfer_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("valid stayed after done");
  property p_byte;
    dn && !o_word |=> df inside {32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF};
  endproperty
  a_byte: assert property (p_byte) else $error("bad byte step");
  property p_word;
    dn && o_word |=> df inside {32'h0000_0000, 32'h0000_0002, 32'hFFFF_FFFE};
  endproperty
  a_word: assert property (p_word) else $error("bad word step");
  property p_nmi;
    i_nmi ##1 (i_nmi && !o_xfer_valid) |=> !o_xfer_valid;
  endproperty
  a_nmi: assert property (p_nmi) else $error("unit started after nmi");
  property p_stby;
    i_standby [*2] |-> !o_xfer_valid;
  endproperty
  a_stby: assert property (p_stby) else $error("unit during standby");
  property p_rst;
    $fell(i_rst) |-> !o_xfer_valid && o_reg_rdata == 32'h0000_0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_irq;
    o_transfer_end_irq |=> !o_transfer_end_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq longer than a cycle");
  c_word: cover property (dn && o_word);
  c_irq: cover property (o_transfer_end_irq);
  c_nmi: cover property (i_nmi && o_xfer_valid);
endmodule

//--- test/dfac_bus_model.sv
// bus partner: one done pulse per unit, prompt or slow
`timescale 1ns/1ps
module dfac_bus_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // unit request and pacing
  input wire logic i_valid,
  input wire logic i_slow,
  output logic o_done
);
  logic [1:0] wait_n;
  // wait one to three cycles when slow, none when prompt, then answer once
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      wait_n <= 2'h0;
    end else if (o_done || !i_valid) begin
      o_done <= 1'b0;
      wait_n <= i_slow ? 2'($urandom_range(3, 1)) : 2'h0;
    end else if (wait_n != 2'h0) begin
      wait_n <= wait_n - 2'h1;
    end else begin
      o_done <= 1'b1;
    end
  end
endmodule

//--- test/tb.sv
// self-checking bench for the channel controller
`timescale 1ns/1ps
module tb;
  import dfac_pkg::*;
  logic clk = 0, rst, stby = 0, wr = 0, rd = 0, nmi = 0, req = 0, slow = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, q, src, dst, sa, da, e;
  logic valid, done, word, irq;
  logic [7:0] ca, sz, bk;
  logic [15:0] cbv;
  int errors = 0, comparisons = 0, xfers = 0, irqs = 0, cyc = 0, x0, i0, n;
  always #4 clk = ~clk;
  dfac_channel dut_u (.i_core_clk(clk), .i_rst(rst), .i_standby(stby), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_nmi(nmi),
    .i_xfer_req(req), .o_xfer_valid(valid), .o_src_addr(sa), .o_dst_addr(da), .o_word(word),
    .i_xfer_done(done), .o_transfer_end_irq(irq));
  dfac_bus_model bus_u (.i_core_clk(clk), .i_rst(rst), .i_valid(valid), .i_slow(slow), .o_done(done));
  task automatic test_done();
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // unit, interrupt and cycle counts with hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (valid === 1'b1 && done === 1'b1) xfers <= xfers + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 50000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
  function automatic logic [31:0] nsrc(input logic [31:0] s, input logic [7:0] c, input int k);
    logic [31:0] st;
    st = c[6] ? STEP_WORD : STEP_BYTE;
    if (!c[4]) return s;
    return c[5] ? s - st * k : s + st * k;
  endfunction
  // load addresses and counts, then arm and enable
  task automatic start(input logic [7:0] c, input logic [7:0] b, input logic [31:0] na, input logic [31:0] nb);
    src = 32'h0010_0000 + {20'h0_0000, 12'($urandom)};
    dst = src ^ 32'h0000_8000;
    wreg(ADDR_SRC, src);
    wreg(ADDR_DST, dst);
    wreg(ADDR_COUNT_A, na);
    wreg(ADDR_COUNT_B, nb);
    rreg(ADDR_CTRL_B);
    wreg(ADDR_CTRL_B, {24'h00_0000, b});
    x0 = xfers;
    i0 = irqs;
    rreg(ADDR_CTRL_A);
    wreg(ADDR_CTRL_A, {24'h00_0000, c});
  endtask
  task automatic finish(input int k);
    for (int j = 0; j < 4000 && xfers != x0 + k; j++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk(xfers - x0, k);
    e = nsrc(src, ca, k);
    chk(sa & 32'h00FF_FFFF, e & 32'h00FF_FFFF);
    chk(da & 32'h00FF_FFFF, dst & 32'h00FF_FFFF);
  endtask
  initial begin
    rst <= 1'b1;
    void'($urandom(32315));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wreg(ADDR_CTRL_A, 32'h0000_00C6);
    rreg(ADDR_CTRL_A);
    chk(q, 32'h0000_0046);
    rreg(ADDR_CTRL_B);
    chk(q, 32'h0000_0000);
    wreg(4'hF, 32'h0000_00FF);
    rreg(4'hF);
    chk(q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      ca = 8'h86 | {1'b0, i[0], i[1], i != 5, i[2], 3'h0};
      n = $urandom_range(5, 1);
      cbv = 16'($urandom);
      slow <= 1'($urandom);
      start(ca, 8'h80, n, cbv);
      finish(n);
      chk(irqs - i0, {31'h0, ca[3]});
      rreg(ADDR_CTRL_A);
      chk(q, {24'h00_0000, ca & 8'h7F});
      rreg(ADDR_COUNT_A);
      chk(q & 32'h0000_FFFF, 32'h0000_0000);
      rreg(ADDR_COUNT_B);
      chk(q & 32'h0000_FFFF, {16'h0000, cbv});
    end
    for (int i = 0; i < 2; i++) begin
      sz = $urandom_range(3, 1);
      bk = $urandom_range(3, 1);
      ca = 8'h9F | {1'b0, i[0], 6'h00};
      start(ca, 8'h80, {16'h0000, sz, sz}, {24'h00_0000, bk});
      finish(sz * bk);
      rreg(ADDR_COUNT_A);
      chk(q & 32'h0000_FFFF, {16'h0000, sz, sz});
      rreg(ADDR_COUNT_B);
      chk(q & 32'h0000_FFFF, 32'h0000_0000);
    end
    ca = 8'h86;
    start(ca, 8'h84, 3, 0);
    repeat (10) @(posedge clk);
    chk(xfers - x0, 0);
    req <= 1'b1;
    finish(3);
    req <= 1'b0;
    start(ca, 8'h80, 40, 0);
    repeat (5) @(posedge clk);
    nmi <= 1'b1;
    repeat (2) @(posedge clk);
    nmi <= 1'b0;
    repeat (8) @(posedge clk);
    n = xfers;
    repeat (10) @(posedge clk);
    chk(xfers - n, 0);
    rreg(ADDR_CTRL_B);
    wreg(ADDR_CTRL_B, 32'h0000_0080);
    finish(40);
    for (int i = 0; i < 2; i++) begin
      start(i ? 8'h86 : 8'h84, i ? 8'h00 : 8'h80, 3, 0);
      repeat (10) @(posedge clk);
      chk(xfers - x0, 0);
    end
    wreg(ADDR_COUNT_A, 32'h0000_1234);
    wreg(ADDR_CTRL_A, 32'h0000_0046);
    stby <= 1'b1;
    repeat (2) @(posedge clk);
    stby <= 1'b0;
    rreg(ADDR_CTRL_A);
    chk(q, 32'h0000_0000);
    rreg(ADDR_COUNT_A);
    chk(q & 32'h0000_FFFF, 32'h0000_1234);
    test_done();
  end
endmodule
bind dfac_channel dfac_channel_monitor mon_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_standby(i_standby), .i_reg_wr(i_reg_wr), .i_nmi(i_nmi), .i_xfer_done(i_xfer_done),
  .o_xfer_valid(o_xfer_valid), .o_word(o_word), .o_src_addr(o_src_addr), .o_dst_addr(o_dst_addr),
  .o_reg_rdata(o_reg_rdata), .o_transfer_end_irq(o_transfer_end_irq));
